// [hw/opc_edge_divider.sv]
/*
 * Divides a slow clock, sampled as a level on sys_clk, by an even ratio.
 * Assumes the slow clock is synchronous to sys_clk and much slower than it.
 */
`timescale 1ns/10ps
`default_nettype none

module opc_edge_divider
    import opc_pkg::*;
#(
    parameter int DIV = OPC_DIV_A
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic srcClk,
    output logic divClk
);

    localparam int HALF = DIV / 2;
    localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    typedef struct packed {
        logic srcPrev;
        logic [CW-1:0] count;
        logic out;
    } opc_div_s;

    opc_div_s state_ff;
    opc_div_s nxt_state;

    // =========================================================
    // Count rising edges, toggle the output every half period
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.srcPrev = srcClk;
        if (srcClk && !state_ff.srcPrev)
        begin
            if (state_ff.count == LAST)
            begin
                nxt_state.count = '0;
                nxt_state.out = !state_ff.out;
            end
            else
            begin
                nxt_state.count = state_ff.count + CW'(1);
            end
        end
    end

    // Counter cleared at reset so the divided phase is repeatable
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign divClk = state_ff.out;

endmodule

`default_nettype wire

// [hw/opc_output_port.sv]
/*
 * Four-bit output port with per-bit high-impedance control, a timer
 * clock output on terminal 2 and an oscillator clock output on terminal 3,
 * plus the stopwatch key swap bit that shares a register.
 * Terminals 0 and 1 are plain outputs. Terminal 2 can carry the selected
 * timer clock and terminal 3 the selected oscillator clock; in both cases
 * the data bit must be 1 and the float bit 0 for the clock to show.
 * Every terminal output, enable and key output comes from a flip-flop, so
 * a register write reaches the pins two edges after its strobe.
 * Registers are four bits wide; bits that are not stored read as zero.
 * Assumes a simple register port (read data one cycle after the read
 * strobe), and that the oscillator and timer clocks arrive as levels
 * synchronous to sys_clk and well below its rate.
 * A source faster than half of sys_clk aliases on the terminal; the
 * block does not detect this.
 * The slow clock dividers start from a known phase at reset only.
 */
`timescale 1ns/10ps
`default_nettype none

module opc_output_port
    import opc_pkg::*;
#(
    parameter int DIV_A = OPC_DIV_A,
    parameter int DIV_B = OPC_DIV_B
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] regAddr,
    input wire logic [3:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [3:0] regRdData,
    input wire logic slowOscClk,
    input wire logic fastOscClk,
    input wire logic timer0Clk,
    input wire logic timer1Clk,
    input wire logic keyIn0,
    input wire logic keyIn1,
    output logic [3:0] portOut,
    output logic [3:0] portOe,
    output logic runStopKey,
    output logic lapKey
);

    // =========================================================
    // Block state, one packed struct
    typedef struct packed {
        // Software-visible registers
        logic [3:0] hiz;
        logic [3:0] data;
        logic fclkEn;
        logic keySwap;
        logic [1:0] freqSel;
        logic tmrOn;
        logic tmrSrc;
        // Read port, zero outside the cycle after a read
        logic [3:0] rdData;
        // Registered terminal and key outputs
        logic [3:0] pinOut;
        logic [3:0] pinOe;
        logic runStop;
        logic lap;
    } opc_state_s;

    opc_state_s state_ff;
    opc_state_s nxt_state;

    // Divided slow clocks
    logic slowDivA;
    logic slowDivB;

    // Selected special clocks, before the data-bit gate
    logic oscClkOut;
    logic timerClkOut;

    // Terminal levels before the float mask
    logic [3:0] pinLevel;

    // =========================================================
    // Slow clock dividers
    // Both count rising edges of the slow clock as seen on sys_clk, so
    // each adds one edge of delay; they run whether or not they are
    // selected, which keeps the switchover free of a restart delay
    // Division ratios are module parameters; both must be even
    opc_edge_divider #(
        .DIV(DIV_A)
    ) divA (
        .sys_clk(sys_clk),
        .rst(rst),
        .srcClk(slowOscClk),
        .divClk(slowDivA)
    );

    // Second divider for the slowest frequency choice
    opc_edge_divider #(
        .DIV(DIV_B)
    ) divB (
        .sys_clk(sys_clk),
        .rst(rst),
        .srcClk(slowOscClk),
        .divClk(slowDivB)
    );

    // =========================================================
    // Clock source selection
    // Plain muxes: switching source or enable may cut a pulse short,
    // which is accepted; no glitch-free switchover is attempted
    // The fast source is passed as sampled; software starts it first
    // The default arm cannot be reached with a two-bit select
    always_comb
    begin
        case (state_ff.freqSel)
            OPC_FREQ_FAST: oscClkOut = fastOscClk;
            OPC_FREQ_SLOW: oscClkOut = slowOscClk;
            OPC_FREQ_DIV_A: oscClkOut = slowDivA;
            OPC_FREQ_DIV_B: oscClkOut = slowDivB;
            default: oscClkOut = 1'h0;
        endcase
    end

    // Timer clock comes straight from the programmable timer inputs
    // The source bit may change while the timer runs; a cut pulse
    // can then reach terminal 2, as with the on/off switch
    assign timerClkOut = state_ff.tmrSrc ? timer1Clk : timer0Clk;

    // =========================================================
    // Terminal levels
    // Terminals 0 and 1 are plain; 2 and 3 gate their special clock
    // behind the data bit, so a data 0 always wins and drives low
    // The float mask is applied later, at the register input, so that
    // a floating terminal reports zero whatever its level would be
    always_comb
    begin
        pinLevel = state_ff.data;
        // Terminal 2: timer clock path
        if (state_ff.data[OPC_TERM_TMR])
        begin
            // Timer output off leaves the terminal high
            pinLevel[OPC_TERM_TMR] = state_ff.tmrOn ? timerClkOut : 1'h1;
        end
        else
        begin
            pinLevel[OPC_TERM_TMR] = 1'h0;
        end
        // Terminal 3: oscillator clock path
        if (state_ff.data[OPC_TERM_FCLK])
        begin
            // Oscillator output off drives the terminal low
            pinLevel[OPC_TERM_FCLK] = state_ff.fclkEn ? oscClkOut : 1'h0;
        end
        else
        begin
            pinLevel[OPC_TERM_FCLK] = 1'h0;
        end
    end

    // =========================================================
    // Register writes, read data, pin and key registers
    // Register map, four data bits each:
    //   clock out and key swap: [0] freq lo, [1] freq hi, [2] key swap,
    //     [3] oscillator clock enable
    //   float control: one bit per terminal, 1 floats it
    //   port data: one bit per terminal
    //   timer out control: [0] timer clock on, [1] timer source,
    //     [3:2] not stored, read as zero
    // The bus never waits, and a read answers in the next cycle only
    always_comb
    begin
        // Hold everything by default; read data fall back to zero
        nxt_state = state_ff;
        nxt_state.rdData = 4'h0;

        // Register writes
        // Only the addressed fields change; a write never touches the
        // read port, so a read may follow a write with no gap
        if (regWr)
        begin
            case (regAddr)
                // Frequency select, key swap and oscillator clock enable
                OPC_ADDR_CLK_KEY:
                begin
                    nxt_state.freqSel[0] = regWrData[OPC_FREQ_LO_BIT];
                    nxt_state.freqSel[1] = regWrData[OPC_FREQ_HI_BIT];
                    nxt_state.keySwap = regWrData[OPC_SWAP_BIT];
                    nxt_state.fclkEn = regWrData[OPC_FCLK_EN_BIT];
                end
                // Float bits, one per terminal
                OPC_ADDR_HIZ:
                begin
                    nxt_state.hiz = regWrData;
                end
                // Terminal data bits
                OPC_ADDR_DATA:
                begin
                    nxt_state.data = regWrData;
                end
                // Timer clock enable and source; upper bits are dropped
                OPC_ADDR_TMR:
                begin
                    nxt_state.tmrOn = regWrData[OPC_TMR_ON_BIT];
                    nxt_state.tmrSrc = regWrData[OPC_TMR_SRC_BIT];
                end
                default:
                begin
                    nxt_state.hiz = state_ff.hiz; // Unmapped writes ignored
                end
            endcase
        end

        // Register reads; unmapped addresses return zero
        // Read data come from the registers as they stand at the read
        // edge, so a read right after a write already sees the new value
        if (regRd)
        begin
            case (regAddr)
                // Fields reassembled at their bit positions
                OPC_ADDR_CLK_KEY:
                begin
                    nxt_state.rdData[OPC_FREQ_LO_BIT] = state_ff.freqSel[0];
                    nxt_state.rdData[OPC_FREQ_HI_BIT] = state_ff.freqSel[1];
                    nxt_state.rdData[OPC_SWAP_BIT] = state_ff.keySwap;
                    nxt_state.rdData[OPC_FCLK_EN_BIT] = state_ff.fclkEn;
                end
                // Float bits read back as written
                OPC_ADDR_HIZ:
                begin
                    nxt_state.rdData = state_ff.hiz;
                end
                // Data bits read back, not the terminal levels
                OPC_ADDR_DATA:
                begin
                    nxt_state.rdData = state_ff.data;
                end
                OPC_ADDR_TMR:
                begin
                    // Bits 3:2 stay at their zero default
                    nxt_state.rdData[OPC_TMR_ON_BIT] = state_ff.tmrOn;
                    nxt_state.rdData[OPC_TMR_SRC_BIT] = state_ff.tmrSrc;
                end
                default:
                begin
                    nxt_state.rdData = 4'h0;
                end
            endcase
        end

        // Pins registered; high-impedance overrides even special output
        // The register adds one edge of delay but keeps mux glitches
        // off the terminals
        nxt_state.pinOut = pinLevel & ~state_ff.hiz;
        nxt_state.pinOe = ~state_ff.hiz;

        // Stopwatch key assignment
        // Swap 0 keeps key 0 on run/stop; keys reach the stopwatch one edge late
        nxt_state.runStop = state_ff.keySwap ? keyIn1 : keyIn0;
        nxt_state.lap = state_ff.keySwap ? keyIn0 : keyIn1;
    end

    // =========================================================
    // State register
    // After reset every terminal drives low: data 0, not floating
    // Reset is synchronous, so it must be held over at least one edge
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            // Software-visible registers
            state_ff.hiz <= OPC_RST_HIZ;
            state_ff.data <= OPC_RST_DATA;
            state_ff.fclkEn <= OPC_RST_BIT;
            state_ff.keySwap <= OPC_RST_BIT;
            state_ff.freqSel <= OPC_RST_FREQ;
            state_ff.tmrOn <= OPC_RST_BIT;
            state_ff.tmrSrc <= OPC_RST_BIT;
            // Read port idle
            state_ff.rdData <= 4'h0;
            // Terminals driven low at once, not one edge later
            state_ff.pinOut <= 4'h0;
            state_ff.pinOe <= 4'hF;
            // Keys released
            state_ff.runStop <= 1'h0;
            state_ff.lap <= 1'h0;
        end
        // Otherwise take the next state whole
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // =========================================================
    // Outputs
    // Every output is a flip-flop of the state register
    assign regRdData = state_ff.rdData;
    assign portOut = state_ff.pinOut;
    assign portOe = state_ff.pinOe;
    assign runStopKey = state_ff.runStop;
    assign lapKey = state_ff.lap;

endmodule

`default_nettype wire

// [hw/opc_pkg.sv]
/*
 * Constants for the four-bit output port with special clock outputs:
 * register addresses, field positions, reset values, frequency codes
 * and divider ratios.
 * Assumes a 16-bit register address and 4-bit register data.
 */
`default_nettype none

package opc_pkg;

    // =========================================================
    // Register addresses
    localparam logic [15:0] OPC_ADDR_CLK_KEY = 16'hFF06;
    localparam logic [15:0] OPC_ADDR_HIZ = 16'hFF30;
    localparam logic [15:0] OPC_ADDR_DATA = 16'hFF31;
    localparam logic [15:0] OPC_ADDR_TMR = 16'hFFC1;

    // =========================================================
    // Field positions
    localparam int OPC_FREQ_LO_BIT = 0;
    localparam int OPC_FREQ_HI_BIT = 1;
    localparam int OPC_SWAP_BIT = 2;
    localparam int OPC_FCLK_EN_BIT = 3;
    localparam int OPC_TMR_ON_BIT = 0;
    localparam int OPC_TMR_SRC_BIT = 1;
    localparam int OPC_TERM_TMR = 2;
    localparam int OPC_TERM_FCLK = 3;

    // =========================================================
    // Reset values
    localparam logic [3:0] OPC_RST_HIZ = 4'h0;
    localparam logic [3:0] OPC_RST_DATA = 4'h0;
    localparam logic [1:0] OPC_RST_FREQ = 2'h0;
    localparam logic OPC_RST_BIT = 1'h0;

    // =========================================================
    // Frequency select codes and divider ratios
    localparam logic [1:0] OPC_FREQ_FAST = 2'h3;
    localparam logic [1:0] OPC_FREQ_SLOW = 2'h2;
    localparam logic [1:0] OPC_FREQ_DIV_A = 2'h1;
    localparam logic [1:0] OPC_FREQ_DIV_B = 2'h0;
    localparam int OPC_DIV_A = 8;
    localparam int OPC_DIV_B = 64;

endpackage

`default_nettype wire

// [sim/opc_ext_load.sv]
/*
 * Load model for the four output terminals: resolves each pin and counts
 * rising edges on the two clock terminals.
 * Assumes the port's registered outputs and one sys_clk domain.
 */
`timescale 1ns/10ps
`default_nettype none

module opc_ext_load
(
    input wire logic sys_clk,
    input wire logic clr,
    input wire logic [3:0] portOut,
    input wire logic [3:0] portOe,
    output logic [3:0] pin,
    output logic [15:0] rise2,
    output logic [15:0] rise3
);
    logic [3:0] last = 4'h0;
    // A floating pin shows a changing pattern, never a settled level
    assign pin = (portOe & portOut) | (~portOe & ~last);
    // Edge counters, cleared by the bench before each window
    always @(posedge sys_clk)
    begin
        last <= pin;
        rise2 <= clr ? 16'h0 : rise2 + 16'(pin[2] & ~last[2]);
        rise3 <= clr ? 16'h0 : rise3 + 16'(pin[3] & ~last[3]);
    end
endmodule

`default_nettype wire

// [sim/opc_output_port_props.sv]
/*
 * Concurrent checks on the output port pins and read port.
 * Assumes register writes land at the strobe edge, pins one edge later.
 */
`timescale 1ns/10ps
`default_nettype none

module opc_output_port_props
    import opc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] regAddr,
    input wire logic [3:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [3:0] regRdData,
    input wire logic keyIn0,
    input wire logic keyIn1,
    input wire logic [3:0] portOut,
    input wire logic [3:0] portOe,
    input wire logic runStopKey,
    input wire logic lapKey
);
    logic [3:0] shHiz, shData, shCk;
    logic [1:0] shTmr, keyPair, plain;
    logic hold2, off2, off3;
    // ==========================================
    // Shadow registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            {shHiz, shData, shCk, shTmr} <= 14'h0;
        else if (regWr)
            case (regAddr)
                OPC_ADDR_HIZ: shHiz <= regWrData;
                OPC_ADDR_DATA: shData <= regWrData;
                OPC_ADDR_CLK_KEY: shCk <= regWrData;
                OPC_ADDR_TMR: shTmr <= regWrData[1:0];
                default: ;
            endcase
    end
    // Expected terminal conditions from the shadows
    assign keyPair = shCk[OPC_SWAP_BIT] ? {keyIn1, keyIn0} : {keyIn0, keyIn1};
    assign plain = shData[1:0] & ~shHiz[1:0];
    assign hold2 = shData[2] & ~shHiz[2] & ~shTmr[0];
    assign off2 = ~shData[2];
    assign off3 = ~shData[3] | ~shCk[OPC_FCLK_EN_BIT];
    // ==========================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_hiz_readback: assert property (
        regRd && regAddr == OPC_ADDR_HIZ |=> regRdData == $past(shHiz))
        else $error("hiz read back wrong");
    a_tmr_upper: assert property (
        regRd && regAddr == OPC_ADDR_TMR |=> regRdData == {2'h0, $past(shTmr)})
        else $error("timer control read wrong");
    a_reset_pins: assert property (
        $fell(rst) |-> portOut == 4'h0 && portOe == 4'hF)
        else $error("pins wrong after reset");
    a_float_enable: assert property (
        !$past(rst) |-> portOe == ~$past(shHiz))
        else $error("enables do not follow hiz");
    a_low_bits: assert property (!$past(rst) |-> portOut[1:0] == $past(plain))
        else $error("plain terminals wrong");
    a_term2_high: assert property ($past(hold2) |-> portOut[2] && portOe[2])
        else $error("terminal 2 not high");
    a_term_low: assert property ($past(off2) |-> !portOut[2])
        else $error("terminal 2 not low");
    a_fclk_off: assert property ($past(off3) |-> !portOut[3])
        else $error("terminal 3 not low");
    a_key_map: assert property (
        !$past(rst) |-> {runStopKey, lapKey} == $past(keyPair))
        else $error("key mapping wrong");
endmodule

bind opc_output_port opc_output_port_props opc_output_port_props_inst (.sys_clk, .rst,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData, .keyIn0, .keyIn1, .portOut, .portOe,
    .runStopKey, .lapKey);

`default_nettype wire

// [sim/tb_top.sv]
/*
 * Bench for the output port: registers, plain output, keys, clock outputs.
 * Assumes the load model; clock sources are bits of a cycle counter.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import opc_pkg::*;
;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic [15:0] regAddr = 16'h0;
    logic [3:0] regWrData = 4'h0;
    logic regWr = 1'h0;
    logic regRd = 1'h0;
    logic keyIn0 = 1'h0;
    logic keyIn1 = 1'h0;
    logic clr = 1'h1;
    logic [15:0] cyc = 16'h0;
    logic [3:0] regRdData, portOut, portOe, pin, rd;
    logic runStopKey, lapKey;
    logic [1:0] kp;
    logic [15:0] rise2, rise3;
    logic [15:0] adr [4] = '{OPC_ADDR_CLK_KEY, OPC_ADDR_HIZ, OPC_ADDR_DATA, OPC_ADDR_TMR};
    logic [15:0] fexp [4] = '{16'h4, 16'h20, 16'h100, 16'h400};
    int n_mismatch = 0;
    int total_checks = 0;
    // Fast clock 2 cycles, slow 8, timer 0 4, timer 1 16; fast runs from start
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 16'h1;
    opc_output_port opc_output_port_inst (.sys_clk, .rst, .regAddr, .regWrData, .regWr,
        .regRd, .regRdData, .slowOscClk(cyc[2]), .fastOscClk(cyc[0]), .timer0Clk(cyc[1]),
        .timer1Clk(cyc[3]), .keyIn0, .keyIn1, .portOut, .portOe, .runStopKey, .lapKey);
    opc_ext_load opc_ext_load_inst (.sys_clk, .clr, .portOut, .portOe, .pin, .rise2, .rise3);
    // ==========================================
    // Bus and compare tasks
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        @(posedge sys_clk);
        regWr <= 1'h1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'h0;
    endtask
    task automatic rdr(input logic [15:0] a);
        @(posedge sys_clk);
        regRd <= 1'h1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'h0;
        #1 rd = regRdData;
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    // Edge window; phase of the sources allows one edge either way
    task automatic count(input int n);
        @(posedge sys_clk);
        clr <= 1'h1;
        @(posedge sys_clk);
        clr <= 1'h0;
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string s, input logic [3:0] e, input logic [3:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    task automatic near(input string s, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if ((g + 16'h1 >= e && g <= e + 16'h1) !== 1'h1)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %0d seen %0d", s, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'h0;
        #1 chk("pins", 4'h0, portOut);
        chk("enables", 4'hF, portOe);
        foreach (adr[i])
        begin
            rdr(adr[i]);
            chk("reset value", 4'h0, rd);
        end
        rdr(16'hFF32);
        chk("unmapped", 4'h0, rd);
        foreach (adr[i])
        begin
            wr(adr[i], 4'hF);
            rdr(adr[i]);
            chk("readback", i == 3 ? 4'h3 : 4'hF, rd);
        end
        $display("test registers done");
        wr(OPC_ADDR_TMR, 4'h0);
        wr(OPC_ADDR_CLK_KEY, 4'h0);
        wr(OPC_ADDR_DATA, 4'h7);
        wr(OPC_ADDR_HIZ, 4'h3);
        settle();
        chk("enables", 4'hC, portOe);
        chk("pins", 4'h4, portOut);
        wr(OPC_ADDR_HIZ, 4'h0);
        settle();
        chk("load", 4'h7, pin);
        wr(OPC_ADDR_DATA, 4'h9);
        settle();
        chk("load", 4'h1, pin);
        $display("test plain output done");
        for (int s = 0; s < 2; s++)
        begin
            wr(OPC_ADDR_CLK_KEY, s == 1 ? 4'h4 : 4'h0);
            for (int k = 0; k < 4; k++)
            begin
                kp = 2'(k);
                @(posedge sys_clk);
                keyIn0 <= kp[0];
                keyIn1 <= kp[1];
                settle();
                chk("keys", {2'h0, kp[s], kp[1 - s]}, {2'h0, runStopKey, lapKey});
            end
        end
        $display("test keys done");
        wr(OPC_ADDR_DATA, 4'hC);
        for (int t = 0; t < 2; t++)
        begin
            wr(OPC_ADDR_TMR, t == 1 ? 4'h3 : 4'h1);
            count(512);
            near("timer edges", t == 1 ? 16'h20 : 16'h80, rise2);
            wr(OPC_ADDR_TMR, 4'h0);
            settle();
            chk("load", 4'h4, pin);
        end
        wr(OPC_ADDR_TMR, 4'h1);
        wr(OPC_ADDR_HIZ, 4'h4);
        settle();
        chk("enables", 4'hB, portOe);
        wr(OPC_ADDR_HIZ, 4'h0);
        wr(OPC_ADDR_DATA, 4'h8);
        settle();
        chk("load", 4'h0, pin);
        $display("test timer output done");
        for (int f = 0; f < 4; f++)
        begin
            wr(OPC_ADDR_CLK_KEY, 4'h8 | 4'(f));
            count(2048);
            near("fclk edges", fexp[f], rise3);
        end
        wr(OPC_ADDR_HIZ, 4'h8);
        settle();
        chk("enables", 4'h7, portOe);
        $display("test clock output done");
        stop_test();
    end
    // Watchdog: the tests need about 9400 cycles
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        n_mismatch++;
        stop_test();
    end
endmodule

`default_nettype wire
